// *** design/tmr_timer.sv ***
// Purpose: 16-bit reload timer with split and capture modes, AHB-Lite
// Assumes: comp1_i and ext_osc_i are asynchronous to clk_i
// Notes:   zero-wait-state slave, always OKAY
//
// Overview of operation
// - timer is a low and high byte; split bit picks 16-bit or two 8-bit.
// - sources are clock, clock/12, ext osc/8, comparator 1, synchronised.
// - 16-bit wrap from FFFF reloads both bytes and sets high flag.
// - in 16-bit mode every full overflow interrupts when timer irq enabled.
// - with low-byte irq enable too, each low byte wrap interrupts.
// - split mode: each byte reloads from its own reload byte.
// - split mode: run bit gates only high byte, low byte always runs.
// - per-byte system_clock bit, else shared field: /12, comp1, reserved, ext/8.
// - split mode: each byte wrap sets its own overflow flag.
// - split: high wrap interrupts; with low enable, either byte does.
// - flags never cleared by hardware; software clears and checks both.
// - capture enable bit selects capture mode; software keeps split at 0.
// - capture on comparator rise or every 8 ext cycles, by field bit 1.
// - capture copies count into reload pair, sets high flag, interrupts.
`timescale 1ns/1ns
module tmr_timer
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // counted sources
  input  wire logic        comp1_i,
  input  wire logic        ext_osc_i,
  // timer interrupt
  output logic             irq_o
);

  // every check below runs on the system clock and sleeps in reset
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  //////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]  ctrl_reg;
  logic [7:0]  rld_lo_reg;
  logic [7:0]  rld_hi_reg;
  logic [1:0]  clock_control_reg_reg;
  logic        irqen_reg;
  logic        wr_pend_reg;
  logic [4:0]  wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic        irq_reg;
  logic [3:0]  div12_reg;
  logic [2:0]  ext_cnt_reg;

  wire split   = ctrl_reg[tmr_pkg::CTRL_SPLIT];
  wire run     = ctrl_reg[tmr_pkg::CTRL_RUN];
  wire cap_en  = ctrl_reg[tmr_pkg::CTRL_CAPEN];
  wire low_ien = ctrl_reg[tmr_pkg::CTRL_LIEN];
  wire hflag   = ctrl_reg[tmr_pkg::CTRL_HFLAG];
  wire lflag   = ctrl_reg[tmr_pkg::CTRL_LFLAG];
  wire [1:0] alt_sel = ctrl_reg[tmr_pkg::CTRL_ALT1:tmr_pkg::CTRL_ALT0];

  //////////////////////////////////////////////////////////////////////////
  // bus decode

  wire addr_ok  = (haddr_i[31:5] == 27'h0000000) && (haddr_i[1:0] == 2'h0);
  wire take     = hsel_i && hready_i && htrans_i[1];
  wire rd_take  = take && !hwrite_i;
  wire wr_take  = take && hwrite_i && addr_ok;

  wire wr_ctrl  = wr_pend_reg && (wr_addr_reg == tmr_pkg::OFS_CTRL);
  wire wr_rldl  = wr_pend_reg && (wr_addr_reg == tmr_pkg::OFS_RLD_LO);
  wire wr_rldh  = wr_pend_reg && (wr_addr_reg == tmr_pkg::OFS_RLD_HI);
  wire wr_cntl  = wr_pend_reg && (wr_addr_reg == tmr_pkg::OFS_CNT_LO);
  wire wr_cnth  = wr_pend_reg && (wr_addr_reg == tmr_pkg::OFS_CNT_HI);
  wire wr_clock_control_reg = wr_pend_reg && (wr_addr_reg == tmr_pkg::OFS_CLOCK_CONTROL_REG);
  wire wr_irqen = wr_pend_reg && (wr_addr_reg == tmr_pkg::OFS_IRQEN);
  wire [7:0] wbyte = hwdata_i[7:0];

  //////////////////////////////////////////////////////////////////////////
  // clock sources

  logic comp_rise;
  logic ext_rise;

  tmr_edge_sync u_comp_sync
  (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (comp1_i),
    .rise_o   (comp_rise)
  );

  tmr_edge_sync u_ext_sync
  (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (ext_osc_i),
    .rise_o   (ext_rise)
  );

  wire tick12 = (div12_reg == tmr_pkg::DIV12_LAST);
  wire ext8   = ext_rise && (ext_cnt_reg == tmr_pkg::DIV8_LAST);

  // per-byte source pick, reserved code never ticks
  function automatic logic pick_tick(input logic sys_sel,
                                     input logic [1:0] alt,
                                     input logic t12,
                                     input logic tcmp,
                                     input logic text8);
    logic t;
    t = 1'b0;
    if (sys_sel)
      t = 1'b1;
    else
      case (alt)
        tmr_pkg::ALT_DIV12: t = t12;
        tmr_pkg::ALT_COMP:  t = tcmp;
        tmr_pkg::ALT_EXT8:  t = text8;
        default:            t = 1'b0;
      endcase
    return t;
  endfunction

  wire tick_lo = pick_tick(clock_control_reg_reg[tmr_pkg::CLOCK_CONTROL_REG_LSYS], alt_sel,
                           tick12, comp_rise, ext8);
  wire tick_hi = pick_tick(clock_control_reg_reg[tmr_pkg::CLOCK_CONTROL_REG_HSYS], alt_sel,
                           tick12, comp_rise, ext8);

  //////////////////////////////////////////////////////////////////////////
  // counting

  logic [7:0] cnt_lo;
  logic [7:0] cnt_hi;
  logic       carry_lo;
  logic       carry_hi;

  // split: low free-running, high gated by run; else 16-bit chain
  wire inc_lo   = split ? tick_lo : (run && tick_lo);
  wire inc_hi   = split ? (run && tick_hi)
                        : (inc_lo && carry_lo);
  wire wrap_lo  = inc_lo && carry_lo;
  wire wrap_hi  = inc_hi && carry_hi;
  // capture mode lets the count roll over instead of reloading
  wire rld_lo_en = split || !cap_en;
  wire rld_hi_en = split || !cap_en;

  tmr_count_byte #(.W(8)) u_lo
  (
    .clk_i        (clk_i),
    .resetn_i     (resetn_i),
    .inc_i        (inc_lo),
    .reload_i     (rld_lo_en && (split || carry_hi)),
    .reload_val_i (rld_lo_reg),
    .wr_i         (wr_cntl),
    .wdata_i      (wbyte),
    .count_o      (cnt_lo),
    .carry_o      (carry_lo)
  );

  tmr_count_byte #(.W(8)) u_hi
  (
    .clk_i        (clk_i),
    .resetn_i     (resetn_i),
    .inc_i        (inc_hi),
    .reload_i     (rld_hi_en),
    .reload_val_i (rld_hi_reg),
    .wr_i         (wr_cnth),
    .wdata_i      (wbyte),
    .count_o      (cnt_hi),
    .carry_o      (carry_hi)
  );

  //////////////////////////////////////////////////////////////////////////
  // capture and flags

  wire cap_evt  = cap_en && (alt_sel[1] ? ext8 : comp_rise);
  wire set_h    = cap_evt || (wrap_hi && (split || !cap_en));
  wire set_l    = wrap_lo;

  // hardware set beats a software clear in the same cycle
  wire [7:0] ctrl_sw   = wr_ctrl ? wbyte : ctrl_reg;
  wire [7:0] ctrl_next = {ctrl_sw[7] | set_h,
                          ctrl_sw[6] | set_l,
                          ctrl_sw[5:0]};

  wire [7:0] rld_lo_next = cap_evt ? cnt_lo :
                           wr_rldl ? wbyte : rld_lo_reg;
  wire [7:0] rld_hi_next = cap_evt ? cnt_hi :
                           wr_rldh ? wbyte : rld_hi_reg;

  wire irq_next = irqen_reg && (hflag || (low_ien && lflag));

  //////////////////////////////////////////////////////////////////////////
  // read mux

  wire [4:0] raddr = haddr_i[4:0];
  wire [7:0] rd_byte =
    (raddr == tmr_pkg::OFS_CTRL)   ? ctrl_reg   :
    (raddr == tmr_pkg::OFS_RLD_LO) ? rld_lo_reg :
    (raddr == tmr_pkg::OFS_RLD_HI) ? rld_hi_reg :
    (raddr == tmr_pkg::OFS_CNT_LO) ? cnt_lo     :
    (raddr == tmr_pkg::OFS_CNT_HI) ? cnt_hi     :
    (raddr == tmr_pkg::OFS_CLOCK_CONTROL_REG)  ? {6'h00, clock_control_reg_reg} :
    (raddr == tmr_pkg::OFS_IRQEN)  ? {7'h00, irqen_reg} : 8'h00;
  wire [31:0] rd_word = addr_ok ? {24'h000000, rd_byte} : 32'h00000000;

  //////////////////////////////////////////////////////////////////////////
  // state

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_reg    <= tmr_pkg::RST_BYTE;
      rld_lo_reg  <= tmr_pkg::RST_BYTE;
      rld_hi_reg  <= tmr_pkg::RST_BYTE;
      clock_control_reg_reg   <= 2'h0;
      irqen_reg   <= 1'b0;
      irq_reg     <= 1'b0;
    end
    else
    begin
      ctrl_reg    <= ctrl_next;
      rld_lo_reg  <= rld_lo_next;
      rld_hi_reg  <= rld_hi_next;
      clock_control_reg_reg   <= wr_clock_control_reg ? wbyte[1:0] : clock_control_reg_reg;
      irqen_reg   <= wr_irqen ? wbyte[tmr_pkg::IRQEN_TMR] : irqen_reg;
      irq_reg     <= irq_next;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 5'h00;
      hrdata_reg  <= 32'h00000000;
    end
    else
    begin
      wr_pend_reg <= wr_take;
      wr_addr_reg <= wr_take ? haddr_i[4:0] : wr_addr_reg;
      hrdata_reg  <= rd_take ? rd_word : hrdata_reg;
    end
  end

  // prescalers: only the synchronised rise moves the ext counter
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      div12_reg   <= 4'h0;
      ext_cnt_reg <= 3'h0;
    end
    else
    begin
      div12_reg   <= tick12 ? 4'h0 : div12_reg + 4'h1;
      ext_cnt_reg <= ext_rise ? ext_cnt_reg + 3'h1 : ext_cnt_reg;
    end
  end

  assign hrdata_o    = hrdata_reg;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign irq_o       = irq_reg;

  //////////////////////////////////////////////////////////////////////////
  // checks

  chk_full_reload: assert property (
    (!split && !cap_en && wrap_hi && !wr_cntl && !wr_cnth) |=>
      ({cnt_hi, cnt_lo} == {$past(rld_hi_reg), $past(rld_lo_reg)}) && hflag)
    else $error("16-bit wrap did not reload");

  chk_wide_stopped: assert property (
    (!split && !run && !wr_cntl && !wr_cnth) |=>
      {cnt_hi, cnt_lo} == {$past(cnt_hi), $past(cnt_lo)})
    else $error("16-bit count moved while stopped");

  chk_split_reload: assert property (
    (split && wrap_lo && !wr_cntl) |=> cnt_lo == $past(rld_lo_reg))
    else $error("low byte did not reload in split mode");

  chk_low_flag: assert property (
    wrap_lo |=> lflag)
    else $error("low wrap did not set low flag");

  chk_split_hflag: assert property (
    (split && wrap_hi) |=> hflag)
    else $error("high wrap did not set high flag in split mode");

  chk_high_gated: assert property (
    (split && !run && !wr_cnth) |=> cnt_hi == $past(cnt_hi))
    else $error("high byte moved while stopped");

  chk_low_free: assert property (
    (split && !run && tick_lo && !carry_lo && !wr_cntl) |=>
      cnt_lo == $past(cnt_lo) + 8'h01)
    else $error("low byte stalled in split mode");

  chk_reserved_idle: assert property (
    (!clock_control_reg_reg[tmr_pkg::CLOCK_CONTROL_REG_LSYS] && alt_sel == tmr_pkg::ALT_RSVD) |->
      !tick_lo)
    else $error("reserved source produced a tick");

  chk_capture_copy: assert property (
    cap_evt |=> ({rld_hi_reg, rld_lo_reg} ==
                 {$past(cnt_hi), $past(cnt_lo)}) && hflag)
    else $error("capture did not copy count");

  chk_flag_sticky: assert property (
    (hflag && !wr_ctrl) |=> hflag)
    else $error("high flag cleared by hardware");

  chk_lflag_sticky: assert property (
    (lflag && !wr_ctrl) |=> lflag)
    else $error("low flag cleared by hardware");

  chk_irq_high: assert property (
    (irqen_reg && hflag) |=> irq_o)
    else $error("no interrupt on high flag");

  chk_irq_low: assert property (
    (irqen_reg && low_ien && lflag) |=> irq_o)
    else $error("no interrupt on low flag");

  chk_irq_quiet: assert property (
    (!irqen_reg || (!hflag && !(low_ien && lflag))) |=> !irq_o)
    else $error("spurious interrupt");

  chk_div12_gap: assert property (
    tick12 |=> !tick12 [*8])
    else $error("divide-by-12 enable too frequent");

  // the eighth rise must fold the prescaler back to its start
  chk_ext_div8: assert property (
    (ext_rise && ext_cnt_reg == tmr_pkg::DIV8_LAST) |=>
      (ext_cnt_reg == 3'h0) && !ext8)
    else $error("ext divide-by-8 misaligned");

  cov_full_wrap:  cover property (@(posedge clk_i) !split && wrap_hi);
  cov_split_low:  cover property (@(posedge clk_i) split && wrap_lo);
  cov_capture:    cover property (@(posedge clk_i) cap_evt);
  cov_flag_race:  cover property (@(posedge clk_i) wr_ctrl && set_h);

endmodule // tmr_timer

// *** design/tmr_pkg.sv ***
// Purpose: shared constants for the three-mode reload/capture timer
// Assumes: 100 MHz system clock, 32-bit AHB-Lite register window
// Notes:   register offsets are byte addresses, one word each
package tmr_pkg;

  // register byte offsets
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_RLD_LO = 5'h04;
  localparam logic [4:0] OFS_RLD_HI = 5'h08;
  localparam logic [4:0] OFS_CNT_LO = 5'h0C;
  localparam logic [4:0] OFS_CNT_HI = 5'h10;
  localparam logic [4:0] OFS_CLOCK_CONTROL_REG  = 5'h14;
  localparam logic [4:0] OFS_IRQEN  = 5'h18;

  // timer_control_reg fields
  localparam int CTRL_HFLAG = 7;
  localparam int CTRL_LFLAG = 6;
  localparam int CTRL_LIEN  = 5;
  localparam int CTRL_CAPEN = 4;
  localparam int CTRL_SPLIT = 3;
  localparam int CTRL_RUN   = 2;
  localparam int CTRL_ALT1  = 1;
  localparam int CTRL_ALT0  = 0;

  // clock_control_reg and extended_irq_enable_reg fields
  localparam int CLOCK_CONTROL_REG_HSYS = 1;
  localparam int CLOCK_CONTROL_REG_LSYS = 0;
  localparam int IRQEN_TMR  = 0;

  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;

  // alt_source_select encodings
  localparam logic [1:0] ALT_DIV12 = 2'h0;
  localparam logic [1:0] ALT_COMP  = 2'h1;
  localparam logic [1:0] ALT_RSVD  = 2'h2;
  localparam logic [1:0] ALT_EXT8  = 2'h3;

  // prescaler counts
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [2:0] DIV8_LAST  = 3'h7;

  // ahb
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

endpackage

// *** design/tmr_edge_sync.sv ***
// Purpose: bring an asynchronous level into clk_i and mark its rise
// Assumes: input slower than half the system clock
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
module tmr_edge_sync
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // async level in, one-cycle rise pulse out
  input  wire logic async_i,
  output logic      rise_o
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign rise_o = sync_reg & ~last_reg;

endmodule // tmr_edge_sync

// *** design/tmr_count_byte.sv ***
// Purpose: one counting half of the timer
// Assumes: reload only takes effect on the increment that wraps
// Notes:   software write beats any increment in the same cycle
`timescale 1ns/1ns
module tmr_count_byte
#(
  parameter int W = 8
)
(
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  // counting control
  input  wire logic         inc_i,
  input  wire logic         reload_i,
  input  wire logic [W-1:0] reload_val_i,
  // software access
  input  wire logic         wr_i,
  input  wire logic [W-1:0] wdata_i,
  // state
  output logic      [W-1:0] count_o,
  output logic              carry_o
);

  // a one-bit counter has no distinct top value to wrap from
  if (W < 2)
  begin : g_width_check
    $error("tmr_count_byte: W must be at least 2");
  end

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  wire  [W-1:0] count_inc = count_reg + {{(W-1){1'b0}}, 1'b1};
  wire          at_top    = &count_reg;

  assign count_next = wr_i ? wdata_i :
                      !inc_i ? count_reg :
                      (at_top && reload_i) ? reload_val_i : count_inc;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

  assign count_o = count_reg;
  assign carry_o = at_top;

endmodule // tmr_count_byte

// *** tb/tmr_src_model.sv ***
// Purpose: far-side sources, comparator output and external oscillator
// Assumes: edges land at no fixed phase to the system clock
// Notes:   both lines stand low between bursts, as an idle source would
`timescale 1ns/1ns
module tmr_src_model
(
  // source outputs
  output logic comp1_o,
  output logic ext_osc_o
);
  initial
  begin
    comp1_o   = 1'b0;
    ext_osc_o = 1'b0;
  end

  // the odd 3 ns slides the edges 3 ns against the clock on each pulse
  task automatic comp_burst(input int n, input int half_ns);
    repeat (n)
    begin
      #(half_ns + 3) comp1_o = 1'b1;
      #(half_ns) comp1_o = 1'b0;
    end
  endtask

  task automatic ext_burst(input int n, input int half_ns);
    repeat (n)
    begin
      #(half_ns + 3) ext_osc_o = 1'b1;
      #(half_ns) ext_osc_o = 1'b0;
    end
  endtask
endmodule // tmr_src_model

// *** tb/testbench.sv ***
// Purpose: self-checking bench for the reload/capture timer
// Assumes: zero-wait slave; one idle cycle left after every transfer
// Notes:   counts are judged through masks where sync jitter blurs them
`timescale 1ns/1ns
module testbench;
  logic        clk_i;
  logic        resetn_i;
  logic        hsel_i;
  logic [31:0] haddr_i;
  logic [1:0]  htrans_i;
  logic        hwrite_i;
  logic [2:0]  hsize_i;
  logic [31:0] hwdata_i;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  logic        comp1_i;
  logic        ext_osc_i;
  logic        irq_o;
  int          num_errors;
  int          total_checks;
  logic [7:0]  rd;

  localparam logic [7:0] RUN  = 8'h01 << tmr_pkg::CTRL_RUN;
  localparam logic [7:0] SPL  = 8'h01 << tmr_pkg::CTRL_SPLIT;
  localparam logic [7:0] CAP  = 8'h01 << tmr_pkg::CTRL_CAPEN;
  localparam logic [7:0] LIEN = 8'h01 << tmr_pkg::CTRL_LIEN;

  tmr_timer DUT
  (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .hsel_i     (hsel_i),
    .haddr_i    (haddr_i),
    .htrans_i   (htrans_i),
    .hwrite_i   (hwrite_i),
    .hsize_i    (hsize_i),
    .hready_i   (hreadyout_o),
    .hwdata_i   (hwdata_i),
    .hrdata_o   (hrdata_o),
    .hreadyout_o(hreadyout_o),
    .hresp_o    (hresp_o),
    .comp1_i    (comp1_i),
    .ext_osc_i  (ext_osc_i),
    .irq_o      (irq_o)
  );

  tmr_src_model PARTNER
  (
    .comp1_o  (comp1_i),
    .ext_osc_o(ext_osc_i)
  );

  always #5 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp,
                        input logic [7:0] mask, input string what);
    total_checks++;
    if ((got & mask) !== (exp & mask))
    begin
      num_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp,
                           input string what);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %0t %s got %b", $time, what, got);
    end
  endtask

  // one transfer; the leading edge wait leaves an idle cycle between
  task automatic xfer(input logic [4:0] a, input logic w,
                      input logic [7:0] d);
    @(posedge clk_i);
    haddr_i  <= {27'h0, a};
    hwrite_i <= w;
    htrans_i <= tmr_pkg::HTRANS_NONSEQ;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= {24'h0, d};
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o[7:0];
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp,
                        input logic [7:0] mask, input string what);
    xfer(a, 1'b0, 8'h00);
    check8(rd, exp, mask, what);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    wr(5'h1C, 8'hFF);
    for (int a = 0; a <= 28; a += 4)
      rd_chk(5'(a), 8'h00, 8'hFF, "reset or unmapped value");
    check_bit(irq_o, 1'b0, "irq after reset");
    check_bit(hresp_o, 1'b0, "okay response");
    $display("test reset done");
  endtask

  task automatic t_wide();
    wr(tmr_pkg::OFS_CLOCK_CONTROL_REG, 8'h01);
    wr(tmr_pkg::OFS_IRQEN, 8'h01);
    wr(tmr_pkg::OFS_RLD_LO, 8'h00);
    wr(tmr_pkg::OFS_RLD_HI, 8'h80);
    wr(tmr_pkg::OFS_CNT_LO, 8'hFE);
    wr(tmr_pkg::OFS_CNT_HI, 8'hFF);
    wr(tmr_pkg::OFS_CTRL, RUN);
    repeat (20) @(posedge clk_i);
    rd_chk(tmr_pkg::OFS_CNT_HI, 8'h80, 8'hFF, "reloaded high");
    rd_chk(tmr_pkg::OFS_CTRL, 8'hC4, 8'hFF, "flags kept");
    check_bit(irq_o, 1'b1, "irq on overflow");
    wr(tmr_pkg::OFS_CTRL, RUN);
    rd_chk(tmr_pkg::OFS_CTRL, RUN, 8'hFF, "flags cleared");
    check_bit(irq_o, 1'b0, "irq after clear");
    wr(tmr_pkg::OFS_CTRL, 8'h00);
    $display("test wide mode done");
  endtask

  task automatic t_low();
    wr(tmr_pkg::OFS_CNT_HI, 8'h00);
    wr(tmr_pkg::OFS_CNT_LO, 8'hF0);
    wr(tmr_pkg::OFS_CTRL, RUN | LIEN);
    repeat (30) @(posedge clk_i);
    rd_chk(tmr_pkg::OFS_CTRL, 8'h64, 8'hFF, "low flag only");
    check_bit(irq_o, 1'b1, "low wrap irq");
    wr(tmr_pkg::OFS_CTRL, RUN | 8'h40);
    repeat (2) @(posedge clk_i);
    check_bit(irq_o, 1'b0, "low irq gated");
    wr(tmr_pkg::OFS_CTRL, 8'h00);
    $display("test low wrap done");
  endtask

  task automatic t_split();
    wr(tmr_pkg::OFS_CLOCK_CONTROL_REG, 8'h03);
    wr(tmr_pkg::OFS_RLD_LO, 8'h80);
    wr(tmr_pkg::OFS_RLD_HI, 8'hA0);
    wr(tmr_pkg::OFS_CNT_LO, 8'hFE);
    wr(tmr_pkg::OFS_CNT_HI, 8'hFE);
    wr(tmr_pkg::OFS_CTRL, SPL);
    repeat (20) @(posedge clk_i);
    rd_chk(tmr_pkg::OFS_CTRL, 8'h48, 8'hFF, "low flag split");
    check_bit(irq_o, 1'b0, "no irq low only");
    rd_chk(tmr_pkg::OFS_CNT_HI, 8'hFE, 8'hFF, "high held");
    rd_chk(tmr_pkg::OFS_CNT_LO, 8'h80, 8'hC0, "low reload");
    wr(tmr_pkg::OFS_CTRL, SPL | RUN);
    repeat (20) @(posedge clk_i);
    rd_chk(tmr_pkg::OFS_CTRL, 8'h80, 8'h80, "high flag split");
    rd_chk(tmr_pkg::OFS_CNT_HI, 8'hA0, 8'hE0, "high reload");
    check_bit(irq_o, 1'b1, "high irq split");
    wr(tmr_pkg::OFS_CTRL, 8'h00);
    $display("test split done");
  endtask

  // alt 00 /12, 01 comparator, 10 no ticks, 11 ext/8 (40 rises give 5)
  task automatic t_src();
    logic [7:0] exp [4] = '{8'h10, 8'h05, 8'h00, 8'h05};
    logic [7:0] msk [4] = '{8'hF0, 8'hFF, 8'hFF, 8'hFF};
    wr(tmr_pkg::OFS_CLOCK_CONTROL_REG, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      wr(tmr_pkg::OFS_CNT_LO, 8'h00);
      wr(tmr_pkg::OFS_CNT_HI, 8'h00);
      wr(tmr_pkg::OFS_CTRL, RUN | 8'(k));
      fork
        PARTNER.comp_burst(5, 50);
        PARTNER.ext_burst(40, 30);
      join
      repeat (40) @(posedge clk_i);
      wr(tmr_pkg::OFS_CTRL, 8'h00);
      rd_chk(tmr_pkg::OFS_CNT_LO, exp[k], msk[k], "source count");
    end
    $display("test sources done");
  endtask

  task automatic t_cap();
    logic [15:0] a;
    logic [15:0] b;
    wr(tmr_pkg::OFS_CLOCK_CONTROL_REG, 8'h01);
    wr(tmr_pkg::OFS_CTRL, CAP | RUN);
    PARTNER.comp_burst(1, 50);
    repeat (10) @(posedge clk_i);
    rd_chk(tmr_pkg::OFS_CTRL, 8'h80, 8'h80, "capture flag");
    check_bit(irq_o, 1'b1, "capture irq");
    xfer(tmr_pkg::OFS_RLD_LO, 1'b0, 8'h00);
    a[7:0] = rd;
    xfer(tmr_pkg::OFS_RLD_HI, 1'b0, 8'h00);
    a[15:8] = rd;
    wr(tmr_pkg::OFS_CTRL, CAP | RUN);
    repeat (60) @(posedge clk_i);
    PARTNER.comp_burst(1, 50);
    repeat (10) @(posedge clk_i);
    xfer(tmr_pkg::OFS_RLD_LO, 1'b0, 8'h00);
    b[7:0] = rd;
    xfer(tmr_pkg::OFS_RLD_HI, 1'b0, 8'h00);
    b[15:8] = rd;
    b = b - a;
    check8(b[15:8], 8'h00, 8'hFF, "period high");
    check8(b[7:0], 8'h40, 8'hC0, "period low");
    wr(tmr_pkg::OFS_CTRL, CAP | RUN | 8'h02);
    PARTNER.ext_burst(7, 30);
    repeat (10) @(posedge clk_i);
    rd_chk(tmr_pkg::OFS_CTRL, 8'h00, 8'h80, "no capture at 7");
    PARTNER.ext_burst(1, 30);
    repeat (10) @(posedge clk_i);
    rd_chk(tmr_pkg::OFS_CTRL, 8'h80, 8'h80, "capture at 8");
    check_bit(irq_o, 1'b1, "ext capture irq");
    wr(tmr_pkg::OFS_IRQEN, 8'h00);
    // the interrupt register follows the enable one clock later
    repeat (2) @(posedge clk_i);
    check_bit(irq_o, 1'b0, "irq masked");
    wr(tmr_pkg::OFS_CTRL, 8'h00);
    $display("test capture done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i        = 1'b0;
    resetn_i     = 1'b0;
    hsel_i       = 1'b1;
    haddr_i      = 32'h0;
    htrans_i     = 2'h0;
    hwrite_i     = 1'b0;
    hsize_i      = tmr_pkg::HSIZE_WORD;
    hwdata_i     = 32'h0;
    num_errors   = 0;
    total_checks = 0;
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_wide();
    t_low();
    t_split();
    t_src();
    t_cap();
    summarize();
  end

  // all tests take under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    $display("FAIL %0t watchdog expired", $time);
    summarize();
  end
endmodule // testbench
